// ===== cpss_conv_model.sv
// Converter front end that feeds raw counts to the sequencer
`timescale 1ns/100ps
module cpss_conv_model (
  input  wire logic                  clk_i,
  input  wire logic                  conv_run_i,
  input  wire logic                  low_power_i,
  input  wire cpss_pkg::cpss_color_s color_val_i,
  input  wire logic [15:0]           prox_val_i,
  output cpss_pkg::cpss_color_s      conv_color_o,
  output logic [15:0]                conv_prox_o
);
  logic run_q;

  always_ff @(posedge clk_i) begin
    run_q <= conv_run_i;
  end

  // Colour counts are only valid around a conversion, prox counts outside low power; elsewhere show junk
  assign conv_color_o = (conv_run_i | run_q) ? color_val_i
                                             : ~color_val_i;
  assign conv_prox_o  = low_power_i ? ~prox_val_i : prox_val_i;
endmodule // cpss_conv_model

// ===== cpss_params.svh
// Timing counts, field widths and reset values of the sensor sequencer
`ifndef CPSS_PARAMS_SVH
`define CPSS_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and time bases
// ----------------------------------------------------------------------
`define CPSS_CLK_PERIOD_NS   40
`define CPSS_STEP_TIME_NS    2400000
`define CPSS_STEP_CYC        (`CPSS_STEP_TIME_NS / `CPSS_CLK_PERIOD_NS)
`define CPSS_PULSE_PERIOD_NS 14000
`define CPSS_PULSE_CYC       (`CPSS_PULSE_PERIOD_NS / `CPSS_CLK_PERIOD_NS)
`define CPSS_WAIT_LONG_MULT  12

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define CPSS_RES_W           16
`define CPSS_UNIT_W          12
`define CPSS_PERS_W          4
`define CPSS_RESULT_RST      16'h0000
`define CPSS_CURRENT_RST     2'h0
`define CPSS_GAIN_RST        2'h0

`endif

// ===== cpss_pkg.sv
// Types shared by the sensor sequencer and its surroundings
package cpss_pkg;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_COLOR = 2'b01,
    ST_PROX  = 2'b10,
    ST_WAIT  = 2'b11
  } cpss_state_e;

  // Emitter sink current selection
  typedef enum logic [1:0] {
    CUR_12MA5 = 2'b00,
    CUR_25MA  = 2'b01,
    CUR_50MA  = 2'b10,
    CUR_100MA = 2'b11
  } cpss_current_e;

  typedef struct packed {
    logic [15:0] red;
    logic [15:0] green;
    logic [15:0] blue;
    logic [15:0] clear;
  } cpss_color_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } cpss_thr_s;

endpackage : cpss_pkg

// ===== cpss_sequencer.sv
// Measurement sequencer, result buffers and interrupt logic of the sensor
// Operation
// [R01] Four colour channels convert together, each result up to 16 bits.
// [R02] Results pass a double buffer; reads never see half-updated values.
// [R03] Serial slave up to fast mode; host keeps clock within that rate.
// [R04] Enabled interrupt asserts as a level and holds until host clears.
// [R05] Result above upper or below lower threshold is a threshold event.
// [R06] Count consecutive events; interrupt at persistence; in-range restarts.
// [R07] Colour and proximity have own thresholds and persistence, separate.
// [R08] Emitter is a current sink at 12.5, 25, 50 or 100 mA.
// [R09] Each proximity measurement emits the programmed 1 to 255 pulses.
// [R10] Emitter pulses are spaced on a fixed 14 us period.
// [R11] Interrupt pin is open drain, pulled low when asserted.
// [R12] Sequencer may enter a low-power wait between measurements.
// [R13] Wait timer programmable from 2.4 ms to over seven seconds.
// [R14] Host sets colour gain and integration time.
// [R15] Interrupt released when nothing enabled is pending.
// [R16] Emitter released outside an active pulse train.
`timescale 1ns/100ps
`include "cpss_params.svh"

module cpss_sequencer #(
  parameter int STEP_CYC  = `CPSS_STEP_CYC,
  parameter int PULSE_CYC = `CPSS_PULSE_CYC,
  parameter int LONG_MULT = `CPSS_WAIT_LONG_MULT
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 power_on_i,
  input  wire logic                 color_en_i,
  input  wire logic                 prox_en_i,
  input  wire logic                 wait_en_i,
  input  wire logic                 wait_long_i,
  input  wire logic [7:0]           wait_steps_i,
  input  wire logic [7:0]           integ_steps_i,
  input  wire logic [1:0]           gain_i,
  input  wire logic [7:0]           pulse_count_i,
  input  wire cpss_pkg::cpss_current_e led_current_i,
  input  wire cpss_pkg::cpss_thr_s  color_thr_i,
  input  wire cpss_pkg::cpss_thr_s  prox_thr_i,
  input  wire logic [3:0]           color_pers_i,
  input  wire logic [3:0]           prox_pers_i,
  input  wire logic                 color_int_en_i,
  input  wire logic                 prox_int_en_i,
  input  wire logic                 color_int_clr_i,
  input  wire logic                 prox_int_clr_i,
  input  wire logic                 host_read_busy_i,
  input  wire cpss_pkg::cpss_color_s conv_color_i,
  input  wire logic [15:0]          conv_prox_i,
  output logic                      conv_run_o,
  output logic [1:0]                gain_o,
  output cpss_pkg::cpss_current_e   led_current_o,
  output logic                      emitter_sink_out_o,
  output logic                      emitter_sink_out_oe_o,
  output logic                      int_o,
  output logic                      int_oe_o,
  output logic                      color_int_o,
  output logic                      prox_int_o,
  output logic                      low_power_o,
  output cpss_pkg::cpss_color_s     color_result_o,
  output logic [15:0]               prox_result_o
);

  localparam int MAXC = (STEP_CYC > PULSE_CYC) ? STEP_CYC : PULSE_CYC;
  localparam int CW   = $clog2(MAXC + 1);
  localparam int UW   = `CPSS_UNIT_W;
  localparam int PW   = `CPSS_PERS_W;
  localparam int RW   = `CPSS_RES_W;
  localparam logic [CW-1:0] PULSE_ON = CW'(PULSE_CYC / 2);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic out_of_range(input logic [RW-1:0] v,
                                        input cpss_pkg::cpss_thr_s t);
    out_of_range = (v > t.upper) || (v < t.lower); // R05
  endfunction

  function automatic logic [UW-1:0] at_least_one(input logic [7:0] n);
    at_least_one = (n == 8'h00) ? UW'(1) : UW'(n);
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  cpss_pkg::cpss_state_e state_q, state_d, start_st;
  logic [CW-1:0] cyc_q, cyc_d, last_cyc;
  logic [UW-1:0] unit_q, unit_d, target;
  logic          phase_end, new_phase;
  logic          emit_q, emit_d;
  logic [1:0]    gain_q, gain_d;
  cpss_pkg::cpss_current_e cur_q, cur_d;

  always_comb begin
    start_st = color_en_i ? cpss_pkg::ST_COLOR :
               prox_en_i  ? cpss_pkg::ST_PROX  : cpss_pkg::ST_SLEEP;
    last_cyc = (state_q == cpss_pkg::ST_PROX) ? CW'(PULSE_CYC - 1)
                                               : CW'(STEP_CYC - 1);
    unique case (state_q)
      cpss_pkg::ST_COLOR: target = at_least_one(integ_steps_i); // R14
      cpss_pkg::ST_PROX:  target = at_least_one(pulse_count_i); // R09
      cpss_pkg::ST_WAIT:  target = wait_long_i                  // R13
          ? UW'(at_least_one(wait_steps_i) * LONG_MULT)
          : at_least_one(wait_steps_i);
      cpss_pkg::ST_SLEEP: target = UW'(1);
    endcase
    phase_end = (cyc_q == last_cyc) && (unit_q == target - UW'(1));
    state_d = state_q;
    cyc_d   = cyc_q + CW'(1);
    unit_d  = unit_q;
    gain_d  = gain_q;
    cur_d   = cur_q;
    if (cyc_q == last_cyc) begin
      cyc_d  = '0;
      unit_d = unit_q + UW'(1);
    end
    unique case (state_q)
      cpss_pkg::ST_SLEEP: state_d = start_st;
      cpss_pkg::ST_COLOR: if (phase_end) begin
        state_d = prox_en_i ? cpss_pkg::ST_PROX :
                  wait_en_i ? cpss_pkg::ST_WAIT : start_st;
      end
      cpss_pkg::ST_PROX: if (phase_end) begin
        state_d = wait_en_i ? cpss_pkg::ST_WAIT : start_st; // R12
      end
      cpss_pkg::ST_WAIT: if (phase_end) begin
        state_d = start_st;
      end
    endcase
    if (!power_on_i) begin
      state_d = cpss_pkg::ST_SLEEP;
    end
    // A phase that follows itself restarts its counters as well
    new_phase = (state_d != state_q) || phase_end;
    if (new_phase || state_q == cpss_pkg::ST_SLEEP) begin
      cyc_d  = '0;
      unit_d = '0;
    end
    // Gain and emitter current are frozen per measurement so a mid-run write to them is harmless
    if (state_d == cpss_pkg::ST_COLOR && new_phase) begin
      gain_d = gain_i; // R14
    end
    if (state_d == cpss_pkg::ST_PROX && new_phase) begin
      cur_d = led_current_i; // R08
    end
    emit_d = (state_d == cpss_pkg::ST_PROX) && (cyc_d < PULSE_ON); // R10 R16
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= cpss_pkg::ST_SLEEP;
      cyc_q   <= '0;
      unit_q  <= '0;
      emit_q  <= 1'b0;
      gain_q  <= `CPSS_GAIN_RST;
      cur_q   <= cpss_pkg::cpss_current_e'(`CPSS_CURRENT_RST);
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      unit_q  <= unit_d;
      emit_q  <= emit_d;
      gain_q  <= gain_d;
      cur_q   <= cur_d;
    end
  end

  // ----------------------------------------------------------------------
  // Result buffers and threshold paths (0 colour, 1 proximity)
  // ----------------------------------------------------------------------
  cpss_pkg::cpss_color_s col_sh_q, col_sh_d, col_res_q, col_res_d;
  logic [RW-1:0] prx_sh_q, prx_sh_d, prx_res_q, prx_res_d;
  logic [1:0]    done, pend_q, pend_d, evt, clr, ien;
  logic [RW-1:0] val [2];
  cpss_pkg::cpss_thr_s thr [2];
  logic [PW-1:0] pers [2];
  logic [PW-1:0] pcnt_q [2];
  logic [PW-1:0] pcnt_d [2];
  logic [1:0]    flag_q, flag_d;
  logic          int_oe_q, int_oe_d;

  always_comb begin
    done[0] = phase_end && (state_q == cpss_pkg::ST_COLOR);
    done[1] = phase_end && (state_q == cpss_pkg::ST_PROX);
    val[0]  = conv_color_i.clear;
    val[1]  = conv_prox_i;
    thr[0]  = color_thr_i; // R07
    thr[1]  = prox_thr_i;
    pers[0] = color_pers_i;
    pers[1] = prox_pers_i;
    clr     = {prox_int_clr_i, color_int_clr_i};
    ien     = {prox_int_en_i, color_int_en_i};
    // All four channels are captured on the same edge
    col_sh_d = done[0] ? conv_color_i : col_sh_q; // R01
    prx_sh_d = done[1] ? conv_prox_i : prx_sh_q;
    pend_d   = pend_q | done;
    col_res_d = col_res_q;
    prx_res_d = prx_res_q;
    // Copy only while the host is not mid-read
    if (!host_read_busy_i) begin
      if (pend_q[0]) col_res_d = col_sh_q; // R02
      if (pend_q[1]) prx_res_d = prx_sh_q;
      pend_d = done;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_path
    always_comb begin
      pcnt_d[i] = pcnt_q[i];
      evt[i]    = 1'b0;
      if (done[i]) begin
        if (out_of_range(val[i], thr[i])) begin
          if (pcnt_q[i] != {PW{1'b1}}) pcnt_d[i] = pcnt_q[i] + PW'(1); // R06
          evt[i] = (pcnt_q[i] + PW'(1) >= pers[i]) ||
                   (pcnt_q[i] == {PW{1'b1}});
        end else begin
          pcnt_d[i] = '0; // R06
        end
      end
      // A new event wins over a clear in the same cycle
      flag_d[i] = evt[i] || (flag_q[i] && !clr[i]); // R04
    end
    always_ff @(posedge clk_i) begin
      if (srst_i) pcnt_q[i] <= '0;
      else        pcnt_q[i] <= pcnt_d[i];
    end
  end

  assign int_oe_d = |(flag_q & ien); // R11 R15

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      col_sh_q  <= '0;
      col_res_q <= '0;
      prx_sh_q  <= `CPSS_RESULT_RST;
      prx_res_q <= `CPSS_RESULT_RST;
      pend_q    <= '0;
      flag_q    <= '0;
      int_oe_q  <= 1'b0;
    end else begin
      col_sh_q  <= col_sh_d;
      col_res_q <= col_res_d;
      prx_sh_q  <= prx_sh_d;
      prx_res_q <= prx_res_d;
      pend_q    <= pend_d;
      flag_q    <= flag_d;
      int_oe_q  <= int_oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic lp_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) lp_q <= 1'b0;
    else        lp_q <= (state_d == cpss_pkg::ST_WAIT); // R12
  end

  logic run_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) run_q <= 1'b0;
    else        run_q <= (state_d == cpss_pkg::ST_COLOR);
  end

  // Pin data flops are held low: open-drain pins only ever pull down
  logic zero_q;
  always_ff @(posedge clk_i) zero_q <= 1'b0;

  assign conv_run_o            = run_q;
  assign gain_o                = gain_q;
  assign led_current_o         = cur_q;
  assign emitter_sink_out_o    = zero_q;
  assign emitter_sink_out_oe_o = emit_q;
  assign int_o                 = zero_q;
  assign int_oe_o              = int_oe_q;
  assign color_int_o           = flag_q[0];
  assign prox_int_o            = flag_q[1];
  assign low_power_o           = lp_q;
  assign color_result_o        = col_res_q;
  assign prox_result_o         = prx_res_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Register settings arrive as plain ports; the serial slave sits in
  // front of them, so the checks below cover the sequencing only. R03
  logic [CW-1:0] on_run_q;
  logic [UW-1:0] npulse_q;
  always_ff @(posedge clk_i) begin
    if (srst_i || !emit_q) on_run_q <= '0;
    else                   on_run_q <= on_run_q + CW'(1);
    if (srst_i || state_d != cpss_pkg::ST_PROX) npulse_q <= '0;
    else if (emit_d && !emit_q) npulse_q <= phase_end ? UW'(1)
                                                      : npulse_q + UW'(1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_int_hold: assert property (flag_q[0] && !color_int_clr_i |=> // R04
    flag_q[0]) else $error("colour interrupt dropped without clear");
  a_int_released: assert property (!color_int_en_i && !prox_int_en_i // R15
    |=> !int_oe_o) else $error("interrupt driven while disabled");
  a_int_low: assert property (int_oe_o |-> int_o == 1'b0) // R11
    else $error("interrupt pin not pulled low");
  a_emit_idle: assert property (emitter_sink_out_oe_o |-> // R16
    state_q == cpss_pkg::ST_PROX) else $error("emitter on outside train");
  a_pulse_width: assert property ($fell(emitter_sink_out_oe_o) && // R10
    state_q == cpss_pkg::ST_PROX |-> on_run_q == PULSE_ON)
    else $error("emitter pulse width wrong");
  a_pulse_count: assert property (state_q == cpss_pkg::ST_PROX && // R09
    phase_end |-> npulse_q == target) else $error("pulse count wrong");
  a_pers_event: assert property (done[0] && // R06
    out_of_range(val[0], thr[0]) &&
    pcnt_q[0] + PW'(1) >= color_pers_i |=> color_int_o)
    else $error("persistence event missed");
  a_pers_restart: assert property (done[1] && // R06
    !out_of_range(val[1], thr[1]) |=> pcnt_q[1] == '0)
    else $error("persistence count not restarted");
  a_result_stable: assert property (host_read_busy_i |=> // R02
    $stable(color_result_o)) else $error("result changed mid-read");
  a_wait_lowpow: assert property (state_q == cpss_pkg::ST_WAIT |-> // R12
    low_power_o) else $error("wait without low power");

endmodule // cpss_sequencer

// ===== cpss_sequencer_tb_top.sv
// Self-checking bench of the measurement sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  err_count++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
  end end
module cpss_sequencer_tb_top;
  localparam int STEP = 20;
  localparam int PCYC = 10;
  typedef struct {
    logic [7:0]              n;
    cpss_pkg::cpss_current_e cur;
    logic [15:0]             val;
    int                      exp_n;
    logic                    flag;
  } cpss_tb_row_s;
  logic clk_i = 1'b0, srst_i = 1'b1;
  logic pwr = 0, cen = 0, pen = 1, wen = 1, wlong = 0, busy = 0;
  logic cien = 0, pien = 1, cclr = 0, pclr = 0;
  logic [7:0] wsteps = 8'h32, integ = 8'h02, pcnt = 8'h01;
  logic [3:0] cpers = 4'h1, ppers = 4'h1;
  logic [1:0] gain = 2'h0;
  cpss_pkg::cpss_current_e pcur = cpss_pkg::CUR_12MA5;
  cpss_pkg::cpss_thr_s     cthr = '{16'h1000, 16'h0100};
  cpss_pkg::cpss_thr_s     pthr = '{16'h0200, 16'h0040};
  cpss_pkg::cpss_color_s   cval = '0, conv_c, color_res, old;
  logic [15:0] pval = 16'h0, conv_p, prox_res;
  logic conv_run, es_out, es_oe, int_pin, int_oe, cflag, pflag, low_power;
  logic [1:0] gain_q;
  cpss_pkg::cpss_current_e led_cur;
  int err_count = 0, comparisons = 0;
  int pulses = 0, last_rise = 0, cyc = 0, run_len = 0, lp_len = 0;
  logic oe_q = 0, run_q = 0, lp_q = 0;
  cpss_tb_row_s rows [5] = '{
    '{8'h01, cpss_pkg::CUR_12MA5, 16'h0100, 1, 1'b0},
    '{8'h03, cpss_pkg::CUR_25MA,  16'h0201, 3, 1'b1},
    '{8'h00, cpss_pkg::CUR_50MA,  16'h003F, 1, 1'b1},
    '{8'hFF, cpss_pkg::CUR_100MA, 16'h0200, 255, 1'b0},
    '{8'h02, cpss_pkg::CUR_25MA,  16'h0040, 2, 1'b0}};
  logic [15:0] cvals [7] = '{16'h2000, 16'h2000, 16'h0800, 16'h0050,
                             16'h1001, 16'h2000, 16'h0800};
  logic        cexp  [7] = '{0, 0, 0, 0, 0, 1, 1};

  always #20 clk_i = ~clk_i;

  cpss_sequencer #(.STEP_CYC(STEP), .PULSE_CYC(PCYC), .LONG_MULT(12)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .power_on_i(pwr), .color_en_i(cen),
    .prox_en_i(pen), .wait_en_i(wen), .wait_long_i(wlong),
    .wait_steps_i(wsteps), .integ_steps_i(integ), .gain_i(gain),
    .pulse_count_i(pcnt), .led_current_i(pcur), .color_thr_i(cthr),
    .prox_thr_i(pthr), .color_pers_i(cpers), .prox_pers_i(ppers),
    .color_int_en_i(cien), .prox_int_en_i(pien), .color_int_clr_i(cclr),
    .prox_int_clr_i(pclr), .host_read_busy_i(busy), .conv_color_i(conv_c),
    .conv_prox_i(conv_p), .conv_run_o(conv_run), .gain_o(gain_q),
    .led_current_o(led_cur), .emitter_sink_out_o(es_out),
    .emitter_sink_out_oe_o(es_oe), .int_o(int_pin), .int_oe_o(int_oe),
    .color_int_o(cflag), .prox_int_o(pflag), .low_power_o(low_power),
    .color_result_o(color_res), .prox_result_o(prox_res));

  cpss_conv_model u_conv (
    .clk_i(clk_i), .conv_run_i(conv_run), .low_power_i(low_power),
    .color_val_i(cval), .prox_val_i(pval), .conv_color_o(conv_c),
    .conv_prox_o(conv_p));

  // ----------------------------------------------------------------
  // Pin monitor: pulse spacing, phase lengths, pin data levels held low
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (!srst_i) begin
      `CHK("emitter level", 1'b0, es_out)
      `CHK("int level", 1'b0, int_pin)
      if (es_oe === 1'b1 && !oe_q) begin
        if (pulses > 0) `CHK("pulse period", PCYC, cyc - last_rise)
        pulses++;
        last_rise = cyc;
      end
    end
    if (conv_run === 1'b1) run_len = run_q ? run_len + 1 : 1;
    if (low_power === 1'b1) lp_len = lp_q ? lp_len + 1 : 1;
    oe_q = (es_oe === 1'b1);
    run_q = (conv_run === 1'b1);
    lp_q = (low_power === 1'b1);
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic lp_wait(logic lvl);
    int t;
    t = 0;
    while (low_power !== lvl && t < 5000) begin
      step();
      t++;
    end
    `CHK("phase change", lvl, low_power)
  endtask

  task automatic next_meas();
    lp_wait(1'b0);
    lp_wait(1'b1);
    step(2);
  endtask

  task automatic summarize();
    $display("counts: %0d compared, %0d wrong", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(16);
    `CHK("reset int", 1'b0, int_oe)
    `CHK("reset emitter", 1'b0, es_oe)
    `CHK("reset result", 64'h0, color_res)
    `CHK("reset wait", 1'b0, low_power)
    srst_i = 0;
    $display("test reset done");
    foreach (rows[i]) begin
      pcnt = rows[i].n;
      pcur = rows[i].cur;
      pval = rows[i].val;
      pclr = 1;
      step();
      pclr = 0;
      step();
      `CHK("int cleared", 1'b0, int_oe)
      pulses = 0;
      pwr = 1;
      next_meas();
      `CHK("pulses", rows[i].exp_n, pulses)
      `CHK("current", rows[i].cur, led_cur)
      `CHK("prox result", rows[i].val, prox_res)
      `CHK("prox flag", rows[i].flag, pflag)
      `CHK("int pin", rows[i].flag, int_oe)
      $display("test prox row %0d done", i);
    end
    pwr = 0;
    pen = 0;
    cen = 1;
    gain = 2'h2;
    cpers = 4'h3;
    cien = 1;
    pclr = 1;
    step();
    pclr = 0;
    step(2);
    pwr = 1;
    foreach (cvals[i]) begin
      cval = '{cvals[i] + 16'h1, cvals[i] + 16'h2, cvals[i] + 16'h3, cvals[i]};
      pulses = 0;
      next_meas();
      `CHK("colour result", cval, color_res)
      `CHK("colour flag", cexp[i], cflag)
      `CHK("integration", 2 * STEP, run_len)
      `CHK("gain", 2'h2, gain_q)
      `CHK("no pulses", 0, pulses)
      `CHK("prox apart", 1'b0, pflag)
      $display("test colour step %0d done", i);
    end
    cien = 0;
    pien = 0;
    step(2);
    `CHK("int masked", 1'b0, int_oe)
    `CHK("flag kept", 1'b1, cflag)
    cien = 1;
    pien = 1;
    step(2);
    `CHK("int held", 1'b1, int_oe)
    cclr = 1;
    step();
    cclr = 0;
    step(2);
    `CHK("flag cleared", 1'b0, cflag)
    `CHK("int released", 1'b0, int_oe)
    old = color_res;
    busy = 1;
    cval = {4{16'h0900}};
    next_meas();
    `CHK("frozen result", old, color_res)
    busy = 0;
    step(2);
    `CHK("released result", cval, color_res)
    $display("test interrupt and freeze done");
    lp_wait(1'b0);
    wsteps = 8'h03;
    next_meas();
    lp_wait(1'b0);
    `CHK("wait short", 3 * STEP, lp_len)
    wlong = 1;
    next_meas();
    lp_wait(1'b0);
    `CHK("wait long", 3 * STEP * 12, lp_len)
    pwr = 0;
    step(3);
    `CHK("sleep", 1'b0, conv_run)
    $display("test wait timer done");
    // Wait disabled: a phase must follow itself, then colour leads prox
    cen = 0;
    pen = 1;
    wen = 0;
    pcnt = 8'h02;
    pval = 16'h0123;
    pulses = 0;
    pwr = 1;
    step(30);
    pval = 16'h0321;
    step(25);
    `CHK("prox repeat", 16'h0321, prox_res)
    `CHK("pulses run", 6, pulses)
    `CHK("no wait", 1'b0, low_power)
    cen = 1;
    pulses = 0;
    step(50);
    `CHK("colour then prox", 1'b1, es_oe)
    `CHK("integration run", 2 * STEP, run_len)
    $display("test back to back done");
    summarize();
  end
endmodule // cpss_sequencer_tb_top
